// ---- ustl_defs.svh ----
// How it works
// - instant operation raises trip in the same tick as start
// - fixed delay trips after delay of continuous pick-up, level ignored
// - inverse time equals dial over one minus ratio to the exponent
// - delay type picks fixed or inverse, fixed by default
// - fixed delay in 5 ms steps, default 40 ms, zero is instant
// - dial in 10 ms steps, default 50 ms, inverse mode only
// - exponent in hundredths, default 1.00
// - release delay in 5 ms steps, default 60 ms, holds start
// - delayed release on: start drops after delay; off: at once
// - continue timing keeps operate timer counting during release, only with rstAfter set
// - on and off events for start, trip, block, dead-line inhibit
// - per event selection of on, off or both
// - clearable counters for start, trip and blocked
// - four independent stages
// - twelve newest records per stage, oldest overwritten
// - record on rising start, trip or blocked with voltages and stamp
// - block at pick-up gives blocked; block during start releases normally
// - below nonzero block level inhibits trip until all lines above pick-up
`ifndef USTL_DEFS_SVH
`define USTL_DEFS_SVH
`define USTL_CLK_KHZ       25000
`define USTL_TICK_US       5000
`define USTL_DIAL_STEP_US  10000
`define USTL_PRETRIG_US    20000
`define USTL_PREFAULT_US   200000
`define USTL_STAGES        4
`define USTL_LOG_DEPTH     12
// per stage register block, stride 0x80
`define USTL_STAGE_STRIDE  7
`define USTL_OFF_CTRL      7'h00
`define USTL_OFF_OPDLY     7'h04
`define USTL_OFF_DIAL      7'h08
`define USTL_OFF_EXPO      7'h0c
`define USTL_OFF_RELDLY    7'h10
`define USTL_OFF_EVSEL     7'h14
`define USTL_OFF_STATUS    7'h18
`define USTL_OFF_REMAIN    7'h1c
`define USTL_OFF_CNT_START 7'h20
`define USTL_OFF_CNT_TRIP  7'h24
`define USTL_OFF_CNT_BLK   7'h28
`define USTL_OFF_CNTCLR    7'h2c
`define USTL_OFF_LOGIDX    7'h30
`define USTL_OFF_LOG_TIME  7'h34
`define USTL_OFF_LOG_INFO  7'h38
`define USTL_OFF_LOG_VOLT  7'h3c
`define USTL_OFF_LOG_PRE   7'h40
// ctrl bits
`define USTL_CTRL_DTYPE    0
`define USTL_CTRL_DELREL   1
`define USTL_CTRL_RSTAFT   2
`define USTL_CTRL_CONT     3
`define USTL_CTRL_BLKEN    4
`define USTL_CTRL_RST      5'h16
`define USTL_OPDLY_RST     19'h00008
`define USTL_DIAL_RST      13'h0005
`define USTL_EXPO_RST      12'h064
`define USTL_RELDLY_RST    15'h000c
`define USTL_EVSEL_RST     8'hff
`endif

// ---- ustl_log.sv ----
`include "ustl_defs.svh"
`default_nettype none
module ustl_log #(
  parameter int DEPTH = `USTL_LOG_DEPTH
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst,
  // capture
  input wire logic [2:0]           rise,
  input wire ustl_pkg::ustl_rec_s  recIn,
  // read, index 0 is newest
  input wire logic [3:0]           rdIdx,
  output ustl_pkg::ustl_rec_s      rdRec
);
  ustl_pkg::ustl_rec_s mem_q [DEPTH];
  ustl_pkg::ustl_rec_s mem_d [DEPTH];
  logic [2:0] pend_q, pend_d, want, pick;
  logic [3:0] wp_q, wp_d, cnt_q, cnt_d;
  int         ra;

  // coincident starts and trips are queued so neither record is lost
  always_comb begin
    mem_d  = mem_q;
    wp_d   = wp_q;
    cnt_d  = cnt_q;
    want   = pend_q | rise;
    pick   = want & (~want + 3'h1);
    pend_d = want & ~pick;
    if (pick != 3'h0) begin
      mem_d[wp_q]      = recIn;
      mem_d[wp_q].evId = pick[0] ? 2'd0 : (pick[1] ? 2'd1 : 2'd2);
      wp_d  = (wp_q == 4'(DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
      cnt_d = (cnt_q == 4'(DEPTH)) ? cnt_q : cnt_q + 4'h1;
    end
    ra = int'(wp_q) - 1 - int'(rdIdx);
    if (ra < 0) ra = ra + DEPTH;
    if (ra < 0) ra = 0;
    rdRec = (rdIdx < cnt_q) ? mem_q[ra] : '0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      pend_q <= 3'h0;
      wp_q   <= 4'h0;
      cnt_q  <= 4'h0;
    end else begin
      mem_q  <= mem_d;
      pend_q <= pend_d;
      wp_q   <= wp_d;
      cnt_q  <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ---- ustl_meas_model.sv ----
`default_nettype none
module ustl_meas_model (
  // clock and tick
  input wire logic        mclk,
  input wire logic        evalTick,
  // wanted levels
  input wire logic [3:0]  wantPick,
  input wire logic [3:0]  wantBlk,
  // measurement side
  output logic [3:0]      pickUp,
  output logic [3:0]      blockIn,
  output logic [31:0]     timeStamp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pickUp = 4'h0;
    blockIn = 4'h0;
    timeStamp = 32'h0;
  end
  // move only just after a tick, like the real element's cycle
  always @(posedge mclk) begin
    if (evalTick) begin
      pickUp <= wantPick;
      blockIn <= wantBlk;
      timeStamp <= timeStamp + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ---- ustl_pkg.sv ----
`default_nettype none
package ustl_pkg;
  typedef enum logic [1:0] {TS_IDLE, TS_RUN, TS_REL} ustl_tstate_e;
  typedef struct packed {
    logic        delayType;
    logic        delRel;
    logic        rstAfter;
    logic        contTime;
    logic        blkEn;
    logic [18:0] opDly;
    logic [12:0] dial;
    logic [11:0] expo;
    logic [14:0] relDly;
  } ustl_cfg_s;
  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0]  evId;
    logic [2:0]  phases;
    logic [2:0]  setGroup;
    logic [15:0] preTrig;
    logic [15:0] faultV;
    logic [15:0] preFault;
    logic [19:0] remain;
  } ustl_rec_s;
endpackage
`default_nettype wire

// ---- ustl_stg_if.sv ----
`default_nettype none
interface ustl_stg_if;
  logic                tick;
  logic                pickUp;
  logic                blockIn;
  logic                belowBlock;
  logic                allAbove;
  logic [15:0]         ratio;
  ustl_pkg::ustl_cfg_s cfg;
  logic                start;
  logic                trip;
  logic                blocked;
  logic                deadInh;
  logic [19:0]         remain;
  modport timer (input tick, pickUp, blockIn, belowBlock, allAbove, ratio, cfg,
                 output start, trip, blocked, deadInh, remain);
  modport ctrl  (output tick, pickUp, blockIn, belowBlock, allAbove, ratio, cfg,
                 input start, trip, blocked, deadInh, remain);
endinterface
`default_nettype wire

// ---- ustl_timer.sv ----
`include "ustl_defs.svh"
`default_nettype none
module ustl_timer (
  // stage link
  ustl_stg_if.timer s,
  // clock and reset
  input wire logic  mclk,
  input wire logic  rst
);
  ustl_pkg::ustl_tstate_e state_q, state_d;
  logic [19:0] elap_q, elap_d, remain_q, remain_d;
  logic [14:0] rel_q, rel_d;
  logic        start_q, start_d, trip_q, trip_d, blk_q, blk_d, dead_q, dead_d;
  logic [5:0]  dcnt_q, dcnt_d;
  logic [31:0] drem_q, drem_d, dquo_q, dquo_d, opInv_q, opInv_d;
  logic [16:0] dvsr_q, dvsr_d;
  logic [32:0] trial;
  logic [31:0] opTicks;
  logic        eff;

  // ratio q8.8 to the power a/100, result q16; mitchell log and antilog keep it small
  function automatic logic [16:0] powQ16(input logic [15:0] r, input logic [11:0] a);
    logic [3:0]         p;
    logic [15:0]        sh;
    logic signed [13:0] lg;
    logic signed [39:0] y;
    logic [31:0]        neg;
    logic [16:0]        res;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (r[i]) p = 4'(i);
    end
    sh  = r << (4'hf - p);
    lg  = 14'($signed({1'b0, p}) - 6'sd8) * 14'sd256 + $signed({6'h0, sh[14:7]});
    y   = (40'(lg) * $signed({28'h0, a}) * 40'sd1311) >>> 17;
    neg = 32'(-(y >>> 8));
    res = (neg > 32'd16) ? 17'h0 : 17'({9'h1, y[7:0], 8'h0} >> neg);
    if (r == 16'h0) res = 17'h0;
    if (r[15:8] != 8'h0) res = 17'h10000;
    return res;
  endfunction

  function automatic logic [19:0] incSat(input logic [19:0] v);
    return (v == 20'hfffff) ? v : v + 20'h1;
  endfunction

  always_comb begin
    dcnt_d  = dcnt_q;
    drem_d  = drem_q;
    dquo_d  = dquo_q;
    dvsr_d  = dvsr_q;
    opInv_d = opInv_q;
    trial   = 33'h0;
    // inverse time recomputed every tick; new voltage takes effect one tick later
    if (s.tick) begin
      dvsr_d = 17'h10000 - powQ16(s.ratio, s.cfg.expo);
      dquo_d = (32'(s.cfg.dial) * 32'(`USTL_DIAL_STEP_US / `USTL_TICK_US)) << 16;
      drem_d = 32'h0;
      dcnt_d = 6'd32;
    end else if (dcnt_q != 6'd0) begin
      trial = {drem_q, dquo_q[31]};
      if (trial >= {16'h0, dvsr_q}) begin
        drem_d = 32'(trial - {16'h0, dvsr_q});
        dquo_d = {dquo_q[30:0], 1'b1};
      end else begin
        drem_d = trial[31:0];
        dquo_d = {dquo_q[30:0], 1'b0};
      end
      dcnt_d = dcnt_q - 6'd1;
      if (dcnt_q == 6'd1) opInv_d = (dvsr_q == 17'h0) ? 32'hffffffff : dquo_d;
    end
  end

  always_comb begin
    opTicks  = s.cfg.delayType ? opInv_q : {13'h0, s.cfg.opDly};
    eff      = s.pickUp & ~s.blockIn;
    state_d  = state_q;
    elap_d   = elap_q;
    rel_d    = rel_q;
    start_d  = start_q;
    trip_d   = trip_q;
    blk_d    = blk_q;
    dead_d   = dead_q;
    remain_d = remain_q;
    if (s.tick) begin
      blk_d = s.pickUp & s.blockIn;
      if (s.cfg.blkEn & s.belowBlock) dead_d = 1'b1;
      else if (s.allAbove) dead_d = 1'b0;
      case (state_q)
        ustl_pkg::TS_IDLE: begin
          if (eff) begin
            state_d = ustl_pkg::TS_RUN;
            elap_d  = 20'h0;
          end
        end
        ustl_pkg::TS_RUN: begin
          if (eff) begin
            elap_d = incSat(elap_q);
          end else if (trip_q || s.cfg.relDly == 15'h0) begin
            state_d = ustl_pkg::TS_IDLE;
            elap_d  = 20'h0;
          end else begin
            state_d = ustl_pkg::TS_REL;
            rel_d   = 15'h1;
            if (!s.cfg.rstAfter) elap_d = 20'h0;
            else if (s.cfg.contTime) elap_d = incSat(elap_q);
          end
        end
        ustl_pkg::TS_REL: begin
          if (eff) begin
            state_d = ustl_pkg::TS_RUN;
            elap_d  = incSat(elap_q);
          end else if (rel_q >= s.cfg.relDly) begin
            state_d = ustl_pkg::TS_IDLE;
            elap_d  = 20'h0;
          end else begin
            rel_d = rel_q + 15'h1;
            if (s.cfg.rstAfter && s.cfg.contTime) elap_d = incSat(elap_q);
          end
        end
        default: begin
          state_d = ustl_pkg::TS_IDLE;
          elap_d  = 20'h0;
        end
      endcase
      start_d = (state_d == ustl_pkg::TS_RUN) | ((state_d == ustl_pkg::TS_REL) & s.cfg.delRel);
      // zero delay trips in the start tick itself
      trip_d  = (state_d == ustl_pkg::TS_RUN) & eff & ({12'h0, elap_d} >= opTicks) & ~dead_d;
      if (trip_d || state_d == ustl_pkg::TS_IDLE) remain_d = 20'h0;
      else if (opTicks - {12'h0, elap_d} > 32'hfffff) remain_d = 20'hfffff;
      else remain_d = 20'(opTicks - {12'h0, elap_d});
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q  <= ustl_pkg::TS_IDLE;
      elap_q   <= 20'h0;
      rel_q    <= 15'h0;
      start_q  <= 1'b0;
      trip_q   <= 1'b0;
      blk_q    <= 1'b0;
      dead_q   <= 1'b0;
      remain_q <= 20'h0;
      dcnt_q   <= 6'h0;
      drem_q   <= 32'h0;
      dquo_q   <= 32'h0;
      dvsr_q   <= 17'h0;
      opInv_q  <= 32'hffffffff;
    end else begin
      state_q  <= state_d;
      elap_q   <= elap_d;
      rel_q    <= rel_d;
      start_q  <= start_d;
      trip_q   <= trip_d;
      blk_q    <= blk_d;
      dead_q   <= dead_d;
      remain_q <= remain_d;
      dcnt_q   <= dcnt_d;
      drem_q   <= drem_d;
      dquo_q   <= dquo_d;
      dvsr_q   <= dvsr_d;
      opInv_q  <= opInv_d;
    end
  end

  assign s.start   = start_q;
  assign s.trip    = trip_q;
  assign s.blocked = blk_q;
  assign s.deadInh = dead_q;
  assign s.remain  = remain_q;
endmodule
`default_nettype wire

// ---- ustl_top.sv ----
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`include "ustl_defs.svh"
`default_nettype none
module ustl_top #(
  parameter int TICK_CYC = `USTL_TICK_US * `USTL_CLK_KHZ / 1000,
  parameter int NSTG     = `USTL_STAGES
) (
  // clock and reset
  input wire logic         mclk,
  input wire logic         rst,
  // ahb-lite slave
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [2:0]   hsize,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // measurement side, one bit or lane per stage; level, phases, group and stamp shared by all stages
  input wire logic [3:0]   pickUp,
  input wire logic [3:0]   blockIn,
  input wire logic [3:0]   belowBlock,
  input wire logic [3:0]   allAbove,
  input wire logic [63:0]  ratio,
  input wire logic [15:0]  measuredLevel,
  input wire logic [2:0]   faultPhases,
  input wire logic [2:0]   setGroup,
  input wire logic [31:0]  timeStamp,
  // protection outputs
  output logic [3:0]       start,
  output logic [3:0]       trip,
  output logic [3:0]       blocked,
  output logic [3:0]       deadInhibit,
  output logic [31:0]      evPulse,
  output logic [31:0]      evTime,
  output logic             evalTick
);
  localparam int PRE_T = `USTL_PRETRIG_US / `USTL_TICK_US;
  localparam int HIST  = `USTL_PREFAULT_US / `USTL_TICK_US + 1;

  ustl_pkg::ustl_cfg_s cfg_q [NSTG];
  ustl_pkg::ustl_cfg_s cfg_d [NSTG];
  logic [7:0]  evSel_q [NSTG];
  logic [7:0]  evSel_d [NSTG];
  logic [3:0]  logIdx_q [NSTG];
  logic [3:0]  logIdx_d [NSTG];
  logic [15:0] cnt_q [NSTG][3];
  logic [15:0] cnt_d [NSTG][3];
  logic [3:0]  prv_q [NSTG];
  logic [3:0]  cur [NSTG];
  logic [15:0] preStart_q [NSTG];
  logic [15:0] preStart_d [NSTG];
  logic [15:0] hist_q [HIST];
  logic [15:0] hist_d [HIST];
  logic [19:0] remainV [NSTG];
  ustl_pkg::ustl_rec_s recIn [NSTG];
  ustl_pkg::ustl_rec_s rdRec [NSTG];
  logic [16:0] div_q, div_d;
  logic        tick_q, tick_d;
  logic [31:0] evPulse_d, evTime_d, hrdata_d;
  logic        aValid_q, aValid_d, aWrite_q, aWrite_d, rdWait_q, rdWait_d, aMap_q, aMap_d;
  logic [8:0]  aAddr_q, aAddr_d;
  logic        aphase, wrEn;
  logic [1:0]  aStg;
  logic [6:0]  aOff;

  // 5 ms evaluation enable
  always_comb begin
    tick_d = (div_q == 17'(TICK_CYC - 1));
    div_d  = tick_d ? 17'h0 : div_q + 17'h1;
  end

  // voltage history for pre-trigger and pre-fault values
  always_comb begin
    hist_d = hist_q;
    if (tick_q) begin
      hist_d[0] = measuredLevel;
      for (int i = 1; i < HIST; i++) hist_d[i] = hist_q[i - 1];
    end
  end

  for (genvar g = 0; g < NSTG; g++) begin : gStage
    ustl_stg_if stg ();
    assign stg.tick       = tick_q;
    assign stg.pickUp     = pickUp[g];
    assign stg.blockIn    = blockIn[g];
    assign stg.belowBlock = belowBlock[g];
    assign stg.allAbove   = allAbove[g];
    assign stg.ratio      = ratio[16 * g +: 16];
    assign stg.cfg        = cfg_q[g];
    assign cur[g]         = {stg.deadInh, stg.blocked, stg.trip, stg.start};
    assign remainV[g]     = stg.remain;
    assign start[g]       = stg.start;
    assign trip[g]        = stg.trip;
    assign blocked[g]     = stg.blocked;
    assign deadInhibit[g] = stg.deadInh;
    assign recIn[g]       = '{stamp: timeStamp, evId: 2'd0, phases: faultPhases, setGroup: setGroup,
                              preTrig: hist_q[PRE_T], faultV: hist_q[0], preFault: preStart_q[g],
                              remain: stg.remain};
    ustl_timer uTimer (
      .s    (stg.timer),
      .mclk (mclk),
      .rst  (rst)
    );
    ustl_log #(.DEPTH(`USTL_LOG_DEPTH)) uLog (
      .mclk  (mclk),
      .rst   (rst),
      .rise  (cur[g][2:0] & ~prv_q[g][2:0]),
      .recIn (recIn[g]),
      .rdIdx (logIdx_q[g]),
      .rdRec (rdRec[g])
    );
  end

  // events, counters and pre-fault capture
  always_comb begin
    evPulse_d  = 32'h0;
    evTime_d   = evTime;
    cnt_d      = cnt_q;
    preStart_d = preStart_q;
    for (int s = 0; s < NSTG; s++) begin
      for (int k = 0; k < 4; k++) begin
        evPulse_d[8 * s + 2 * k]     = cur[s][k] & ~prv_q[s][k] & evSel_q[s][2 * k];
        evPulse_d[8 * s + 2 * k + 1] = ~cur[s][k] & prv_q[s][k] & evSel_q[s][2 * k + 1];
      end
      if (cur[s][0] & ~prv_q[s][0]) preStart_d[s] = hist_q[HIST - 1];
      for (int k = 0; k < 3; k++) begin
        // an increment in the clearing cycle survives as a count of one
        if (wrEn && aStg == 2'(s) && aOff == `USTL_OFF_CNTCLR && hwdata[k]) cnt_d[s][k] = 16'h0;
        if (cur[s][k] & ~prv_q[s][k]) cnt_d[s][k] = cnt_d[s][k] + 16'h1;
      end
    end
    if (evPulse_d != 32'h0) evTime_d = timeStamp;
  end

  // ahb-lite slave: writes zero wait, reads one wait so read data comes from a flop
  always_comb begin
    aStg      = aAddr_q[8:7];
    aOff      = {aAddr_q[6:2], 2'b00};
    hreadyout = ~(aValid_q & ~aWrite_q & ~rdWait_q);
    hresp     = 1'b0;
    aphase    = hsel & htrans[1] & hready & (hsize == 3'b010);
    wrEn      = aValid_q & aWrite_q & aMap_q;
    aValid_d  = hreadyout ? aphase : aValid_q;
    aWrite_d  = (hreadyout & aphase) ? hwrite : aWrite_q;
    aAddr_d   = (hreadyout & aphase) ? haddr[8:0] : aAddr_q;
    aMap_d    = (hreadyout & aphase) ? (haddr[31:9] == 23'h0) : aMap_q;
    rdWait_d  = aValid_q & ~aWrite_q & ~rdWait_q;
    hrdata_d  = hrdata;
    cfg_d     = cfg_q;
    evSel_d   = evSel_q;
    logIdx_d  = logIdx_q;
    if (wrEn) begin
      case (aOff)
        `USTL_OFF_CTRL: begin
          cfg_d[aStg].delayType = hwdata[`USTL_CTRL_DTYPE];
          cfg_d[aStg].delRel    = hwdata[`USTL_CTRL_DELREL];
          cfg_d[aStg].rstAfter  = hwdata[`USTL_CTRL_RSTAFT];
          cfg_d[aStg].contTime  = hwdata[`USTL_CTRL_CONT];
          cfg_d[aStg].blkEn     = hwdata[`USTL_CTRL_BLKEN];
        end
        `USTL_OFF_OPDLY:  cfg_d[aStg].opDly  = hwdata[18:0];
        `USTL_OFF_DIAL:   cfg_d[aStg].dial   = hwdata[12:0];
        `USTL_OFF_EXPO:   cfg_d[aStg].expo   = hwdata[11:0];
        `USTL_OFF_RELDLY: cfg_d[aStg].relDly = hwdata[14:0];
        `USTL_OFF_EVSEL:  evSel_d[aStg]      = hwdata[7:0];
        `USTL_OFF_LOGIDX: logIdx_d[aStg]     = hwdata[3:0];
        default: begin
        end
      endcase
    end
    if (rdWait_d) begin
      hrdata_d = 32'h0;
      if (aMap_q) begin
        case (aOff)
          `USTL_OFF_CTRL:      hrdata_d = {27'h0, cfg_q[aStg].blkEn, cfg_q[aStg].contTime, cfg_q[aStg].rstAfter,
                                           cfg_q[aStg].delRel, cfg_q[aStg].delayType};
          `USTL_OFF_OPDLY:     hrdata_d = {13'h0, cfg_q[aStg].opDly};
          `USTL_OFF_DIAL:      hrdata_d = {19'h0, cfg_q[aStg].dial};
          `USTL_OFF_EXPO:      hrdata_d = {20'h0, cfg_q[aStg].expo};
          `USTL_OFF_RELDLY:    hrdata_d = {17'h0, cfg_q[aStg].relDly};
          `USTL_OFF_EVSEL:     hrdata_d = {24'h0, evSel_q[aStg]};
          `USTL_OFF_STATUS:    hrdata_d = {28'h0, cur[aStg]};
          `USTL_OFF_REMAIN:    hrdata_d = {12'h0, remainV[aStg]};
          `USTL_OFF_CNT_START: hrdata_d = {16'h0, cnt_q[aStg][0]};
          `USTL_OFF_CNT_TRIP:  hrdata_d = {16'h0, cnt_q[aStg][1]};
          `USTL_OFF_CNT_BLK:   hrdata_d = {16'h0, cnt_q[aStg][2]};
          `USTL_OFF_LOGIDX:    hrdata_d = {28'h0, logIdx_q[aStg]};
          `USTL_OFF_LOG_TIME:  hrdata_d = rdRec[aStg].stamp;
          `USTL_OFF_LOG_INFO:  hrdata_d = {24'h0, rdRec[aStg].evId, rdRec[aStg].phases, rdRec[aStg].setGroup};
          `USTL_OFF_LOG_VOLT:  hrdata_d = {rdRec[aStg].preTrig, rdRec[aStg].faultV};
          `USTL_OFF_LOG_PRE:   hrdata_d = {rdRec[aStg].preFault[11:0], rdRec[aStg].remain};
          default:             hrdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q    <= 17'h0;
      tick_q   <= 1'b0;
      evPulse  <= 32'h0;
      evTime   <= 32'h0;
      hrdata   <= 32'h0;
      aValid_q <= 1'b0;
      aWrite_q <= 1'b0;
      aAddr_q  <= 9'h0;
      aMap_q   <= 1'b0;
      rdWait_q <= 1'b0;
      for (int i = 0; i < HIST; i++) hist_q[i] <= 16'h0;
      for (int s = 0; s < NSTG; s++) begin
        cfg_q[s]      <= '{delayType: 1'b0, delRel: 1'b1, rstAfter: 1'b1, contTime: 1'b0, blkEn: 1'b1,
                           opDly: `USTL_OPDLY_RST, dial: `USTL_DIAL_RST, expo: `USTL_EXPO_RST,
                           relDly: `USTL_RELDLY_RST};
        evSel_q[s]    <= `USTL_EVSEL_RST;
        logIdx_q[s]   <= 4'h0;
        prv_q[s]      <= 4'h0;
        preStart_q[s] <= 16'h0;
        for (int k = 0; k < 3; k++) cnt_q[s][k] <= 16'h0;
      end
    end else begin
      div_q      <= div_d;
      tick_q     <= tick_d;
      evPulse    <= evPulse_d;
      evTime     <= evTime_d;
      hrdata     <= hrdata_d;
      aValid_q   <= aValid_d;
      aWrite_q   <= aWrite_d;
      aAddr_q    <= aAddr_d;
      aMap_q     <= aMap_d;
      rdWait_q   <= rdWait_d;
      hist_q     <= hist_d;
      cfg_q      <= cfg_d;
      evSel_q    <= evSel_d;
      logIdx_q   <= logIdx_d;
      prv_q      <= cur;
      preStart_q <= preStart_d;
      cnt_q      <= cnt_d;
    end
  end

  assign evalTick = tick_q;
endmodule
`default_nettype wire

// ---- ustl_top_monitor.sv ----
`default_nettype none
module ustl_top_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // stage levels
  input wire logic [3:0]  pickUp,
  input wire logic [3:0]  blockIn,
  input wire logic [3:0]  start,
  input wire logic [3:0]  trip,
  input wire logic [3:0]  blocked,
  // events
  input wire logic [31:0] evPulse,
  input wire logic [31:0] evTime,
  input wire logic [31:0] timeStamp,
  input wire logic        evalTick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_out_tick: assert property ($changed(start) |-> $past(evalTick))
    else $error("start moved off tick");
  chk_tick_gap: assert property (evalTick |=> !evalTick [*8])
    else $error("tick too soon");
  chk_trip_start: assert property ((trip & ~start) == 4'h0)
    else $error("trip without start");
  chk_trip_drop: assert property (evalTick |=> (trip & ~$past(pickUp & ~blockIn)) == 4'h0)
    else $error("trip held without pickup");
  chk_block_rise: assert property ((blocked & ~$past(blocked) & ~$past(pickUp & blockIn)) == 4'h0)
    else $error("blocked without cause");
  chk_start_event: assert property ($rose(start[1]) |=> evPulse[8])
    else $error("no start event");
  chk_ev_stamp: assert property (|evPulse |-> evTime == $past(timeStamp))
    else $error("event stamp wrong");
endmodule
`default_nettype wire

// ---- ustl_top_tb.sv ----
`default_nettype none
module ustl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] DEFV [6] = '{32'h16, 32'h8, 32'h5, 32'h64, 32'hc, 32'hff};
  logic        mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
  logic        hreadyout, hresp, evalTick;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, evPulse, evTime, timeStamp;
  logic [3:0]  wantPick = 4'h0, wantBlk = 4'h0, below = 4'h0, pickUp, blockIn, start, trip, blocked, deadInhibit;
  logic [63:0] ratio = 64'h0;
  logic [15:0] measuredLevel = 16'h0;
  logic [5:0]  grp = 6'h0;
  logic [31:0] expQ [$];
  int          nErrors = 0, numChecks = 0, cyc = 0, seed = 32'h81f2, n;
  always #20 mclk = ~mclk;
  ustl_top #(.TICK_CYC(40)) u_ustl_top (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pickUp, .blockIn, .belowBlock(below), .allAbove(~below),
    .ratio, .measuredLevel, .faultPhases(grp[5:3]), .setGroup(grp[2:0]), .timeStamp, .start, .trip,
    .blocked, .deadInhibit, .evPulse, .evTime, .evalTick);
  ustl_meas_model u_ustl_meas_model (.mclk, .evalTick, .wantPick, .wantBlk, .pickUp, .blockIn, .timeStamp);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hreadyout);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk iff evalTick);
    repeat (2) @(posedge mclk);
  endtask
  task automatic setPick(input logic [3:0] p, input logic [3:0] b);
    wantPick <= p;
    wantBlk <= b;
    tick(1);
  endtask
  // read data is judged where it lands, not inside the bus task
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nErrors++;
      wrap_up();
    end
    if (rdPend && hreadyout) begin
      check(hrdata, expQ.pop_front());
      rdPend <= 1'b0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) rdPend <= 1'b1;
  end
  initial begin
    // stage 3 lane held at zero so its inverse time is exactly the dial
    ratio <= {16'h0, 16'($random(seed)), $random(seed)};
    measuredLevel <= 16'($random(seed));
    grp <= 6'($random(seed));
    n = 1 + ($random(seed) & 3);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(32'h180 + 4 * i, DEFV[i]);
    rd(32'h200, 32'h0);
    wr(32'h04, 32'h0);
    wr(32'h84, n);
    wr(32'h90, 32'h2);
    setPick(4'h1, 4'h0);
    tick(1);
    rd(32'h18, 32'h3);
    rd(32'h98, 32'h0);
    setPick(4'h3, 4'h0);
    tick(n);
    rd(32'h98, 32'h1);
    tick(1);
    rd(32'h98, 32'h3);
    // a pick-up that tripped ends at once, with no release hold
    setPick(4'h1, 4'h0);
    tick(1);
    rd(32'h98, 32'h0);
    rd(32'ha4, 32'h1);
    wr(32'hac, 32'h2);
    rd(32'ha4, 32'h0);
    rd(32'ha0, 32'h1);
    // one tick of pick-up, dropped before the trip delay runs out
    setPick(4'h3, 4'h0);
    setPick(4'h1, 4'h0);
    tick(1);
    rd(32'h98, 32'h1);
    tick(2);
    rd(32'h98, 32'h0);
    setPick(4'h5, 4'h4);
    tick(1);
    rd(32'h118, 32'h4);
    rd(32'h128, 32'h1);
    rd(32'h138, {24'h0, 2'h2, grp});
    wr(32'h130, 32'h1);
    rd(32'h138, 32'h0);
    below <= 4'h1;
    tick(1);
    rd(32'h18, 32'h9);
    below <= 4'h0;
    tick(1);
    rd(32'h18, 32'h3);
    wr(32'h180, 32'h17);
    setPick(4'hd, 4'h4);
    tick(1);
    rd(32'h198, 32'h1);
    rd(32'h19c, 32'ha);
    repeat (4) @(posedge mclk);
    wrap_up();
  end
endmodule
bind ustl_top ustl_top_monitor u_ustl_top_monitor (.mclk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .pickUp, .blockIn, .start, .trip, .blocked, .evPulse, .evTime, .timeStamp, .evalTick);
`default_nettype wire
